// *** dv/bpf_framer_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module bpf_framer_asserts
	import bpf_pkg::*;
#(
	parameter int FIELD_WORDS = 2
)
(
	input wire logic                                                 ref_clk_i,
	input wire logic                                                 rst_i,
	input wire logic                                                 start_i,
	input wire logic [BPF_NUM_GROUPS-1:0]                            group_select_i,
	input wire logic [BPF_NUM_GROUPS*FIELD_WORDS*BPF_FIELD_BITS-1:0] field_selection_words_i,
	input wire logic                                                 pay_valid_i,
	input wire logic [7:0]                                           pay_data_i,
	input wire logic                                                 pay_last_i,
	input wire logic                                                 tx_ready_i,
	input wire logic                                                 busy_o,
	input wire logic                                                 pay_ready_o,
	input wire logic                                                 tx_valid_o,
	input wire logic [7:0]                                           tx_data_o,
	input wire logic                                                 tx_last_o
);
	logic [7:0] idx;
	// Byte position inside the packet
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || (tx_valid_o && tx_ready_i && tx_last_o))
			idx <= 8'h00;
		else if (tx_valid_o && tx_ready_i)
			idx <= idx + 8'h01;
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	sequence start_seq;
		start_i && !busy_o && !tx_valid_o;
	endsequence
	sequence sync_seq;
		busy_o ##1 (tx_valid_o && tx_data_o == BPF_SYNC_BYTE);
	endsequence
	sync_first_a: assert property (start_seq |=> sync_seq)
		else $error("sync byte late or wrong");
	sync_slot_a: assert property (tx_valid_o && idx == 8'h00 |-> tx_data_o == BPF_SYNC_BYTE)
		else $error("first byte not sync");
	group_ext_a: assert property (tx_valid_o && idx == 8'h01 |-> !tx_data_o[7])
		else $error("group byte bit seven set");
	hold_stall_a: assert property (tx_valid_o && !tx_ready_i |=>
		tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
		else $error("byte changed while stalled");
	idle_quiet_a: assert property (!busy_o |-> !tx_valid_o && !pay_ready_o)
		else $error("activity while idle");
	end_release_a: assert property (tx_valid_o && tx_ready_i && tx_last_o |=> !tx_valid_o)
		else $error("byte right after packet end");
	min_length_a: assert property (tx_last_o |-> tx_valid_o && idx >= 8'h03)
		else $error("packet too short");
	refuse_start_a: assert property (busy_o && start_i && !tx_last_o |=> busy_o)
		else $error("start broke packet");
	reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !tx_valid_o && !busy_o)
		else $error("output live after reset");
endmodule
bind bpf_framer bpf_framer_asserts #(.FIELD_WORDS(FIELD_WORDS)) u_chk (
	.ref_clk_i(ref_clk_i), .rst_i(rst_i), .start_i(start_i), .group_select_i(group_select_i),
	.field_selection_words_i(field_selection_words_i), .pay_valid_i(pay_valid_i),
	.pay_data_i(pay_data_i), .pay_last_i(pay_last_i), .tx_ready_i(tx_ready_i),
	.busy_o(busy_o), .pay_ready_o(pay_ready_o), .tx_valid_o(tx_valid_o),
	.tx_data_o(tx_data_o), .tx_last_o(tx_last_o));
`default_nettype wire

// *** dv/bpf_framer_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module bpf_framer_tb
	import bpf_pkg::*;
;
	logic         ref_clk_i = 0, rst_i = 1, start_i = 0, pay_valid_i = 0, pay_last_i = 0;
	logic [6:0]   group_select_i = '0;
	logic [209:0] field_selection_words_i = '0, f;
	logic [7:0]   pay_data_i = '0, tx_data_o;
	logic         tx_ready_i, busy_o, pay_ready_o, tx_valid_o, tx_last_o, crc_ok;
	logic [8:0]   exp_q[$];
	int           bad_count = 0, compares = 0;
	always #10 ref_clk_i = ~ref_clk_i;
	bpf_framer #(.FIELD_WORDS(2)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .start_i(start_i),
		.group_select_i(group_select_i), .field_selection_words_i(field_selection_words_i),
		.pay_valid_i(pay_valid_i), .pay_data_i(pay_data_i), .pay_last_i(pay_last_i),
		.tx_ready_i(tx_ready_i), .busy_o(busy_o), .pay_ready_o(pay_ready_o),
		.tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o));
	bpf_host host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .tx_valid_i(tx_valid_o),
		.tx_data_i(tx_data_o), .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i), .crc_ok_o(crc_ok));
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Oldest note against every byte the host takes
	always @(negedge ref_clk_i) begin
		if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
			check({tx_last_o, tx_data_o}, exp_q.size() ? exp_q.pop_front() : 9'bx);
	end
	task automatic packet(input logic [6:0] grp, input logic [209:0] fld, input int n);
		logic [15:0] crc;
		logic [7:0]  b[$];
		logic [14:0] s0, s1;
		int          t, hdr;
		b.push_back({1'b0, grp});
		// one chain per group, low byte first
		for (int g = 0; g < 7; g++) begin
			s0 = fld[g*30 +: 15];
			s1 = fld[g*30+15 +: 15];
			if (grp[g]) begin
				b.push_back(s0[7:0]);
				b.push_back({s1 != 0, s0[14:8]});
				if (s1 != 0) begin
					b.push_back(s1[7:0]);
					b.push_back({1'b0, s1[14:8]});
				end
			end
		end
		hdr = b.size();
		for (int i = 0; i < n; i++)
			b.push_back(8'($urandom));
		// expected bytes, crc high byte first
		exp_q.push_back({1'b0, BPF_SYNC_BYTE});
		crc = BPF_CRC_INIT;
		foreach (b[i]) begin
			exp_q.push_back({1'b0, b[i]});
			crc = crc ^ {b[i], 8'h00};
			for (int k = 0; k < 8; k++)
				crc = crc[15] ? {crc[14:0], 1'b0} ^ 16'h1021 : {crc[14:0], 1'b0};
		end
		exp_q.push_back({1'b0, crc[15:8]});
		exp_q.push_back({1'b1, crc[7:0]});
		@(posedge ref_clk_i);
		start_i <= 1'b1;
		group_select_i <= grp;
		field_selection_words_i <= fld;
		// Start held on into the packet must be ignored
		repeat (3) @(posedge ref_clk_i);
		start_i <= 1'b0;
		for (int i = hdr; i < b.size(); i++) begin
			pay_valid_i <= 1'b1;
			pay_data_i <= b[i];
			pay_last_i <= (i == b.size() - 1);
			t = 0;
			do begin
				@(negedge ref_clk_i);
				t++;
			end while (pay_ready_o !== 1'b1 && t < 300);
			if (t >= 300) begin
				bad_count++;
				end_sim();
			end
			@(posedge ref_clk_i);
		end
		pay_valid_i <= 1'b0;
		t = 0;
		while (exp_q.size() > 0 && t < 500) begin
			@(posedge ref_clk_i);
			t++;
		end
		if (t >= 500) begin
			bad_count++;
			end_sim();
		end
		@(negedge ref_clk_i);
		check({8'h00, crc_ok}, 9'h001);
	endtask
	initial begin
		void'($urandom(32'h3f96));
		repeat (5) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		// receiver time, week, raw bit; attitude bits
		f = '0;
		f[0] = 1'b1;
		f[60 +: 15] = 15'h000C;
		f[90 + BPF_SAT1_TIME_OF_WEEK_BIT] = 1'b1;
		f[90 + BPF_SAT1_WEEK_NUMBER_BIT] = 1'b1;
		f[90 + BPF_SAT1_RAW_MEAS_BIT] = 1'b1;
		f[120 + BPF_ATT_QUATERNION_BIT] = 1'b1;
		f[120 + BPF_ATT_MAGNETIC_NED_BIT] = 1'b1;
		packet(7'h1D, f, 4);
		packet(7'h00, '0, 1);
		packet(7'h7F, '0, 2);
		// random selections, odd runs without extension words
		for (int r = 0; r < 14; r++) begin
			f = 210'({7{$urandom}});
			if (r % 2)
				for (int g = 0; g < 7; g++)
					f[g*30+15 +: 15] = '0;
			packet(7'($urandom), f, 1 + $urandom % 6);
		end
		end_sim();
	end
endmodule
`default_nettype wire

// *** dv/bpf_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module bpf_host
	import bpf_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_last_i,
	output logic            tx_ready_o,
	output logic            crc_ok_o
);
	logic [15:0] crc;
	logic [15:0] nxt;
	logic        first;
	// running sum, sync byte kept out
	always_comb begin
		nxt = crc ^ {tx_data_i, 8'h00};
		for (int i = 0; i < 8; i++)
			nxt = nxt[15] ? {nxt[14:0], 1'b0} ^ BPF_CRC_POLY : {nxt[14:0], 1'b0};
	end
	// residue over packet and crc must be zero
	always_ff @(posedge ref_clk_i) begin
		tx_ready_o <= !rst_i && ($urandom % 3 != 0); // Random stalls
		if (rst_i) begin
			first <= 1'b1;
			crc <= BPF_CRC_INIT;
			crc_ok_o <= 1'b0;
		end else if (tx_valid_i && tx_ready_o) begin
			first <= tx_last_i;
			crc <= (first || tx_last_i) ? BPF_CRC_INIT : nxt;
			if (tx_last_i)
				crc_ok_o <= (nxt == 16'h0000);
		end
	end
endmodule
`default_nettype wire

// *** hdl/bpf_crc16.sv ***
`timescale 1ns/1ns
`default_nettype none

module bpf_crc16
	import bpf_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic        clear_i,
	input  wire logic        update_i,
	input  wire logic [7:0]  data_i,
	output logic      [15:0] crc_o
);

	typedef struct packed {
		logic [15:0] crc;
	} bpf_crc_s;

	bpf_crc_s r;
	bpf_crc_s next_r;

	// MSB-first CRC over one byte; receiver rerunning it across CRC gets zero
	function automatic logic [15:0] bpf_crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] v;
		v = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++) begin
			v = v[15] ? ((v << 1) ^ BPF_CRC_POLY) : (v << 1);
		end
		return v;
	endfunction

	// Clear restarts a packet; clear wins since packets never overlap
	always_comb begin
		next_r = r;
		if (clear_i) begin
			next_r.crc = BPF_CRC_INIT;
		end else if (update_i) begin
			next_r.crc = bpf_crc_byte(r.crc, data_i);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			r.crc <= BPF_CRC_INIT;
		end else begin
			r <= next_r;
		end
	end

	assign crc_o = r.crc;

endmodule

`default_nettype wire

// *** hdl/bpf_framer.sv ***
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Packet is header, payload, then CRC
// - Header length follows selection and extensions
// - First byte is always sync 0xFA
// - Group byte: seven flags, extension bit 7
// - Extension set means another group byte
// - First byte groups 1-7, then 8-14
// - Last group byte has extension clear
// - Group bits map to seven output groups
// - Group eight bit forced to zero
// - Field word MSB flags continuation word
// - Chained words give ascending 15-bit slices
// - Group chain ends before next group
// - Receiver group: tow, week, raw bits
// - Attitude: quaternion bit 2, NED bit 4
// - One field sequence per group, ascending
// - Payload in group order, no padding
// - CRC spans group byte through payload
// - CRC over packet with CRC gives zero
module bpf_framer
	import bpf_pkg::*;
#(
	parameter int FIELD_WORDS = 2
)
(
	input  wire logic                                   ref_clk_i,
	input  wire logic                                   rst_i,
	input  wire logic                                   start_i,
	input  wire logic [BPF_NUM_GROUPS-1:0]              group_select_i,
	input  wire logic [BPF_NUM_GROUPS*FIELD_WORDS*BPF_FIELD_BITS-1:0] field_selection_words_i,
	input  wire logic                                   pay_valid_i,
	input  wire logic [7:0]                             pay_data_i,
	input  wire logic                                   pay_last_i,
	input  wire logic                                   tx_ready_i,
	output logic                                        busy_o,
	output logic                                        pay_ready_o,
	output logic                                        tx_valid_o,
	output logic      [7:0]                             tx_data_o,
	output logic                                        tx_last_o
);

	// Selection bits held per group
	localparam int SEL_BITS = FIELD_WORDS * BPF_FIELD_BITS;
	// Group index meaning no further group selected
	localparam logic [2:0] GRP_NONE = 3'(BPF_NUM_GROUPS);

	// All framer state but the CRC in one register
	typedef struct packed {
		// Sequencing
		bpf_state_e                        state;
		logic [BPF_NUM_GROUPS-1:0]         groups;
		logic [BPF_NUM_GROUPS*SEL_BITS-1:0] fields;
		logic [2:0]                        grp;
		logic [7:0]                        word_idx;
		logic                              low_byte;
		logic                              busy;
		logic                              tx_valid;
		logic [7:0]                        tx_data;
		logic                              tx_last;
		logic                              crc_upd;
	} bpf_frame_s;

	// State, its next value and the CRC link
	bpf_frame_s r;
	bpf_frame_s next_r;
	logic [15:0] crc;
	logic        crc_clear;

	// Last word of a group's chain: no higher selection bits remain
	function automatic logic [7:0] bpf_words_needed(input logic [SEL_BITS-1:0] s);
		logic [7:0] n;
		n = 8'h01;
		for (int w = 1; w < FIELD_WORDS; w++) begin
			if (|(s >> (w * BPF_FIELD_BITS))) begin
				n = 8'(w + 1);
			end
		end
		return n;
	endfunction

	// Build one 16-bit field word with its extension flag
	function automatic logic [15:0] bpf_field_word(input logic [SEL_BITS-1:0] s,
			input logic [7:0] idx);
		logic [15:0] wd;
		logic [7:0]  need;
		need = bpf_words_needed(s);
		wd = 16'h0000;
		wd[BPF_FIELD_BITS-1:0] = 15'(s >> (idx * BPF_FIELD_BITS));
		// Extension set while higher slices still follow
		wd[BPF_EXT_WORD_BIT] = (idx + 8'h01) < need;
		return wd;
	endfunction

	// Next selected group at or above a position, 7 if none
	function automatic logic [2:0] bpf_next_group(input logic [BPF_NUM_GROUPS-1:0] g,
			input logic [2:0] from);
		logic [2:0] n;
		n = GRP_NONE;
		// Scan down so the lowest match is kept
		for (int i = BPF_NUM_GROUPS - 1; i >= 0; i--) begin
			if (g[i] && (3'(i) >= from)) begin
				n = 3'(i);
			end
		end
		return n;
	endfunction

	// Pick one byte of a word: field words leave low first, the CRC high first
	function automatic logic [7:0] bpf_byte_of(input logic [15:0] w, input logic hi);
		logic [7:0] b;
		b = hi ? w[BPF_WORD_BITS-1:BPF_WORD_BITS/2] : w[BPF_WORD_BITS/2-1:0];
		return b;
	endfunction

	// Current group's selection, its word and the handshake terms
	logic [2:0]          sel_grp;
	logic [SEL_BITS-1:0] cur_sel;
	logic [15:0]         cur_word;
	logic [2:0]          next_grp;
	logic                tx_take;
	logic                out_free;

	// Clamp the index so the part-select never reaches past the fields
	assign sel_grp  = (r.grp < GRP_NONE) ? r.grp : 3'h0;
	assign cur_sel  = r.fields[sel_grp*SEL_BITS +: SEL_BITS];
	// Word with its extension flag
	assign cur_word = bpf_field_word(cur_sel, r.word_idx);

	assign next_grp = bpf_next_group(r.groups, r.grp + 3'h1);

	// Byte leaves on ready
	assign tx_take  = r.tx_valid && tx_ready_i;
	// Output register is free when empty or being drained this cycle
	assign out_free = !r.tx_valid || tx_ready_i;

	// Sequencer: loads one byte per free output slot, gapless except one idle cycle before the CRC high byte.
	// A byte loads in the cycle the old one drains, which keeps the stream
	// dense at the cost of a payload ready that is not registered.
	always_comb begin
		// Defaults: no CRC feed, no clear, payload held off
		next_r = r;
		next_r.crc_upd = 1'b0;
		crc_clear = 1'b0;
		pay_ready_o = 1'b0;
		// Drained byte leaves the slot empty unless reloaded below
		if (tx_take) begin
			next_r.tx_valid = 1'b0;
			next_r.tx_last = 1'b0;
		end

		unique case (r.state)
			// Idle: capture the selection on start
			BPF_IDLE: begin
				if (start_i) begin
					next_r.groups = group_select_i;
					next_r.fields = field_selection_words_i;
					next_r.busy = 1'b1;
					next_r.state = BPF_SYNC;
					crc_clear = 1'b1;
				end else if (!r.tx_valid || tx_take) begin
					// Busy falls only once the final byte is taken
					next_r.busy = 1'b0;
				end
			end

			// Sync byte, kept out of the CRC
			BPF_SYNC: begin
				if (out_free) begin
					next_r.tx_valid = 1'b1;
					next_r.tx_data = BPF_SYNC_BYTE;
					next_r.state = BPF_GROUP;
				end
			end

			// Single group selection byte
			BPF_GROUP: begin
				if (out_free) begin
					next_r.tx_valid = 1'b1;
					next_r.tx_data = {1'b0, r.groups};
					next_r.crc_upd = 1'b1;
					next_r.grp = bpf_next_group(r.groups, 3'h0);
					next_r.word_idx = 8'h00;
					next_r.low_byte = 1'b0;
					next_r.state = (|r.groups) ? BPF_FIELD : BPF_PAYLOAD;
				end
			end

			// Field words of each selected group
			BPF_FIELD: begin
				if (out_free) begin
					// slices, low word first, sent low byte first
					next_r.tx_valid = 1'b1;
					next_r.tx_data = bpf_byte_of(cur_word, r.low_byte);
					next_r.crc_upd = 1'b1;
					next_r.low_byte = !r.low_byte;
					// Second byte of a word closes it
					if (r.low_byte) begin
						if (cur_word[BPF_EXT_WORD_BIT]) begin
							next_r.word_idx = r.word_idx + 8'h01;
						end else begin
							// chain ends, go to next group
							next_r.word_idx = 8'h00;
							next_r.grp = next_grp;
							if (next_grp == GRP_NONE) begin
								next_r.state = BPF_PAYLOAD;
							end
						end
					end
				end
			end

			// Payload bytes straight from the source
			BPF_PAYLOAD: begin
				// Ready tracks the sink directly, so no skid buffer is needed
				// payload passed through unpadded in supplied order
				pay_ready_o = out_free;
				if (out_free && pay_valid_i) begin
					next_r.tx_valid = 1'b1;
					next_r.tx_data = pay_data_i;
					next_r.crc_upd = 1'b1;
					// Last payload byte hands over to the CRC
					if (pay_last_i) begin
						next_r.state = BPF_CRC_HI;
					end
				end
			end

			// CRC high byte once the sum has settled
			BPF_CRC_HI: begin
				// CRC settles one cycle after the last payload byte
				if (out_free && !r.crc_upd) begin
					next_r.tx_valid = 1'b1;
					next_r.tx_data = bpf_byte_of(crc, 1'b1);
					next_r.state = BPF_CRC_LO;
				end
			end

			// CRC low byte closes the packet
			BPF_CRC_LO: begin
				if (out_free) begin
					next_r.tx_valid = 1'b1;
					next_r.tx_data = bpf_byte_of(crc, 1'b0);
					next_r.tx_last = 1'b1;
					next_r.state = BPF_IDLE;
				end
			end

			// Unused state code: drop the packet and resynchronise
			default: begin
				next_r = '0;
				next_r.state = BPF_IDLE;
			end
		endcase
	end

	// Single state register; reset clears everything
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			r <= '0;
			r.state <= BPF_IDLE;
		end else begin
			r <= next_r;
		end
	end

	// CRC runs on each byte the cycle after it is loaded, sync excluded;
	// fed from the output register so each byte counts exactly once
	bpf_crc16 u_crc (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.clear_i   (crc_clear),
		.update_i  (r.crc_upd),
		.data_i    (r.tx_data),
		.crc_o     (crc)
	);

	// Outputs come straight from the state register
	assign busy_o     = r.busy;
	assign tx_valid_o = r.tx_valid;
	assign tx_data_o  = r.tx_data;
	assign tx_last_o  = r.tx_last;

endmodule

`default_nettype wire

// *** hdl/bpf_pkg.sv ***
package bpf_pkg;

	// Framing constants
	localparam logic [7:0]  BPF_SYNC_BYTE     = 8'hFA;
	localparam int          BPF_NUM_GROUPS    = 7;
	localparam int          BPF_FIELD_BITS    = 15;
	localparam int          BPF_WORD_BITS     = 16;
	localparam int          BPF_EXT_BYTE_BIT  = 7;
	localparam int          BPF_EXT_WORD_BIT  = 15;
	localparam logic [15:0] BPF_CRC_INIT      = 16'h0000;
	localparam logic [15:0] BPF_CRC_POLY      = 16'h1021;

	// Group bit positions in the group selection byte
	localparam int BPF_GRP_GENERAL  = 0;
	localparam int BPF_GRP_TIME     = 1;
	localparam int BPF_GRP_IMU      = 2;
	localparam int BPF_GRP_SAT1     = 3;
	localparam int BPF_GRP_ATTITUDE = 4;
	localparam int BPF_GRP_NAV      = 5;
	localparam int BPF_GRP_SAT2     = 6;

	// Field selection positions within groups
	localparam int BPF_SAT1_TIME_OF_WEEK_BIT  = 1;
	localparam int BPF_SAT1_WEEK_NUMBER_BIT   = 2;
	localparam int BPF_SAT1_RAW_MEAS_BIT      = 15;
	localparam int BPF_ATT_QUATERNION_BIT     = 2;
	localparam int BPF_ATT_MAGNETIC_NED_BIT   = 4;

	// Framer sequence states
	typedef enum logic [2:0] {
		BPF_IDLE,
		BPF_SYNC,
		BPF_GROUP,
		BPF_FIELD,
		BPF_PAYLOAD,
		BPF_CRC_HI,
		BPF_CRC_LO
	} bpf_state_e;

endpackage
